// file: inc/wdt_params.svh
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// counter and prescaler
`define WDT_CNT_W        16
`define WDT_CNT_MAX      16'hFFFF
`define WDT_CNT_ONE      16'h0001
`define WDT_DIV_FAST     256
`define WDT_DIV_SLOW     16384
`define WDT_PRE_W        14

// default reload: 256 ticks of /256 = 65536 clocks, 6.55 ms at 10 MHz
`define WDT_RELOAD_RST   16'hFF00
`define WDT_DIV_SEL_RST  1'h0

// register port
`define WDT_ADDR_W       8
`define WDT_DATA_W       16
`define WDT_OFF_CTRL     8'h00
`define WDT_OFF_RELOAD   8'h04
`define WDT_OFF_COUNT    8'h08
`define WDT_OFF_STATE    8'h0C
`define WDT_OFF_ISTS     8'h10
`define WDT_OFF_ICLR     8'h14
`define WDT_OFF_IEN      8'h18

// field positions
`define WDT_CTRL_DIV_BIT 0
`define WDT_EV_W         2
`define WDT_EV_WARN      0
`define WDT_EV_RESET     1
`define WDT_ST_ON_BIT    0
`define WDT_ST_WARN_BIT  1
`define WDT_ST_RST_BIT   2

`endif

// file: inc/wdt_pkg.sv
`include "wdt_params.svh"

package wdt_pkg;

  typedef enum logic [1:0] {
    WDT_OFF,
    WDT_RUN,
    WDT_WARN,
    WDT_RESET
  } wdt_state_e;

  // core instructions, one-cycle pulses
  typedef struct packed {
    logic watchdog_enable_instr;
    logic watchdog_disable_instr;
    logic service;
  } wdt_cmd_s;

  // register port request
  typedef struct packed {
    logic [`WDT_ADDR_W-1:0] addr;
    logic [`WDT_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } wdt_bus_s;

  typedef struct packed {
    wdt_state_e             st;
    logic [`WDT_CNT_W-1:0]  cnt;
    logic [`WDT_CNT_W-1:0]  watchdog_reload_value;
    logic                   div_sel;
    logic [`WDT_EV_W-1:0]   sts;
    logic [`WDT_EV_W-1:0]   ien;
    logic                   irq;
    logic                   rst_req;
    logic [`WDT_DATA_W-1:0] rdata;
  } wdt_regs_s;

  typedef struct packed {
    logic [`WDT_PRE_W-1:0] cnt;
  } wdt_pre_s;

endpackage

// file: hdl/wdt_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int DIV_SLOW = `WDT_DIV_SLOW
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // control
  input  wire logic i_clr,
  input  wire logic i_run,
  input  wire logic i_slow,
  // tick to the counter
  output logic      o_tick
);

  localparam logic [`WDT_PRE_W-1:0] LAST_FAST =
    `WDT_PRE_W'(`WDT_DIV_FAST - 1);
  localparam logic [`WDT_PRE_W-1:0] LAST_SLOW =
    `WDT_PRE_W'(DIV_SLOW - 1);

  wdt_pre_s             r_q;
  wdt_pre_s             r_d;
  logic [`WDT_PRE_W-1:0] last;

  assign last   = i_slow ? LAST_SLOW : LAST_FAST;
  assign o_tick = i_run && !i_clr && (r_q.cnt >= last);

  always_comb begin
    r_d = r_q;
    if (i_clr || !i_run || o_tick) begin
      r_d.cnt = '0;
    end else begin
      r_d.cnt = r_q.cnt + `WDT_PRE_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_q.cnt <= '0;
    end else if (i_ce) begin
      r_q <= r_d;
    end
  end

  a_tick_spacing : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_tick |=> (r_q.cnt == '0))
    else $error("prescaler did not restart after tick");

endmodule

`default_nettype wire

// file: hdl/wdt_top.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

// Overview of operation
// - application reset leaves the watchdog enabled and counting
// - disable and enable instructions act at once, in any state except the reset-request state
// - missed service: prewarning interrupt first, then a reset request
// - 16-bit counter advancing on system clock divided by 16384 or 256
// - counter loads from a software-programmed reload register
// - each service in the run or prewarning state reloads the counter and clears the prescaler together
// - default setup gives about 6.5 ms timeout at 10 MHz

module wdt_top
  import wdt_pkg::*;
#(
  parameter int DIV_SLOW = `WDT_DIV_SLOW
) (
  // clock, reset and freeze
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_ce,
  // core instructions
  input  wire wdt_cmd_s               i_cmd,
  // register port
  input  wire wdt_bus_s               i_bus,
  output logic [`WDT_DATA_W-1:0]      o_rdata,
  // events
  output logic                        o_irq,
  output logic                        o_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  wdt_regs_s             r_q;
  wdt_regs_s             r_d;
  logic                  tick;
  logic                  running;
  logic                  svc_ok;
  logic                  ovf;
  logic                  pre_clr;
  logic [`WDT_EV_W-1:0]  ev_set;
  logic [`WDT_EV_W-1:0]  ev_clr;
  logic [`WDT_DATA_W-1:0] rd_val;
  logic [`WDT_DATA_W-1:0] state_word;

  function automatic logic hit(
    input logic [`WDT_ADDR_W-1:0] a,
    input logic [`WDT_ADDR_W-1:0] off
  );
    return a == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // prescaler

  assign running = (r_q.st == WDT_RUN) || (r_q.st == WDT_WARN);
  assign svc_ok  = i_cmd.service && running;
  // a service restarts the prescaler in the same cycle as the reload
  assign pre_clr = svc_ok;

  wdt_prescaler #(
    .DIV_SLOW (DIV_SLOW)
  ) u_pre (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (pre_clr),
    .i_run   (running),
    .i_slow  (r_q.div_sel),
    .o_tick  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // events

  // overflow is the tick that would carry past the maximum count
  assign ovf = running && tick && !svc_ok &&
               (r_q.cnt == `WDT_CNT_MAX);

  always_comb begin
    ev_set = '0;
    ev_set[`WDT_EV_WARN]  = ovf && (r_q.st == WDT_RUN);
    ev_set[`WDT_EV_RESET] = ovf && (r_q.st == WDT_WARN);
  end

  always_comb begin
    ev_clr = '0;
    if (i_bus.wr && hit(i_bus.addr, `WDT_OFF_ICLR)) begin
      ev_clr = i_bus.wdata[`WDT_EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    state_word = '0;
    state_word[`WDT_ST_ON_BIT]   = (r_q.st != WDT_OFF);
    state_word[`WDT_ST_WARN_BIT] = (r_q.st == WDT_WARN);
    state_word[`WDT_ST_RST_BIT]  = (r_q.st == WDT_RESET);
  end

  always_comb begin
    rd_val = '0;
    if (hit(i_bus.addr, `WDT_OFF_CTRL)) begin
      rd_val[`WDT_CTRL_DIV_BIT] = r_q.div_sel;
    end else if (hit(i_bus.addr, `WDT_OFF_RELOAD)) begin
      rd_val = r_q.watchdog_reload_value;
    end else if (hit(i_bus.addr, `WDT_OFF_COUNT)) begin
      rd_val = r_q.cnt;
    end else if (hit(i_bus.addr, `WDT_OFF_STATE)) begin
      rd_val = state_word;
    end else if (hit(i_bus.addr, `WDT_OFF_ISTS)) begin
      rd_val[`WDT_EV_W-1:0] = r_q.sts;
    end else if (hit(i_bus.addr, `WDT_OFF_IEN)) begin
      rd_val[`WDT_EV_W-1:0] = r_q.ien;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_d = r_q;

    // disable beats enable when both arrive together
    case (r_q.st)
      WDT_OFF: begin
        if (i_cmd.watchdog_enable_instr &&
            !i_cmd.watchdog_disable_instr) begin
          r_d.st = WDT_RUN;
        end
      end
      WDT_RUN: begin
        if (i_cmd.watchdog_disable_instr) begin
          r_d.st = WDT_OFF;
        end else if (ovf) begin
          r_d.st = WDT_WARN;
        end
      end
      WDT_WARN: begin
        if (i_cmd.watchdog_disable_instr) begin
          r_d.st = WDT_OFF;
        end else if (svc_ok) begin
          r_d.st = WDT_RUN;
        end else if (ovf) begin
          r_d.st = WDT_RESET;
        end
      end
      WDT_RESET: begin
        // held until the next application reset
        r_d.st = WDT_RESET;
      end
      default: begin
        r_d.st = WDT_RUN;
      end
    endcase

    // counter: reload on service or overflow, else count up on tick
    if (svc_ok || ovf) begin
      r_d.cnt = r_q.watchdog_reload_value;
    end else if (running && tick) begin
      r_d.cnt = r_q.cnt + `WDT_CNT_ONE;
    end

    // software writes
    if (i_bus.wr) begin
      if (hit(i_bus.addr, `WDT_OFF_CTRL)) begin
        r_d.div_sel = i_bus.wdata[`WDT_CTRL_DIV_BIT];
      end else if (hit(i_bus.addr, `WDT_OFF_RELOAD)) begin
        r_d.watchdog_reload_value = i_bus.wdata;
      end else if (hit(i_bus.addr, `WDT_OFF_IEN)) begin
        r_d.ien = i_bus.wdata[`WDT_EV_W-1:0];
      end
    end

    // sticky status: a new event wins over a clear in the same cycle
    r_d.sts = (r_q.sts & ~ev_clr) | ev_set;

    r_d.irq     = |(r_d.sts & r_d.ien);
    r_d.rst_req = (r_d.st == WDT_RESET);

    // read data live for exactly one cycle after the strobe
    r_d.rdata = i_bus.rd ? rd_val : '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_q.st                    <= WDT_RUN;
      r_q.cnt                   <= `WDT_RELOAD_RST;
      r_q.watchdog_reload_value <= `WDT_RELOAD_RST;
      r_q.div_sel               <= `WDT_DIV_SEL_RST;
      r_q.sts                   <= '0;
      r_q.ien                   <= '0;
      r_q.irq                   <= 1'b0;
      r_q.rst_req               <= 1'b0;
      r_q.rdata                 <= '0;
    end else if (i_ce) begin
      r_q <= r_d;
    end
  end

  assign o_rdata     = r_q.rdata;
  assign o_irq       = r_q.irq;
  assign o_reset_req = r_q.rst_req;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_reset_enabled : assert property (@(posedge i_clk) disable iff (1'b0)
    !i_rst_n |=> (r_q.st == WDT_RUN) && !o_reset_req)
    else $error("watchdog not enabled after reset");

  a_default_cfg : assert property (@(posedge i_clk) disable iff (1'b0)
    !i_rst_n |=> (r_q.cnt == `WDT_RELOAD_RST) &&
                 (r_q.div_sel == `WDT_DIV_SEL_RST))
    else $error("default interval setup wrong after reset");

  a_disable_now : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_cmd.watchdog_disable_instr && (r_q.st != WDT_RESET)
    |=> (r_q.st == WDT_OFF))
    else $error("disable instruction not honoured at once");

  a_enable_now : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_cmd.watchdog_enable_instr &&
    !i_cmd.watchdog_disable_instr && (r_q.st == WDT_OFF)
    |=> (r_q.st == WDT_RUN))
    else $error("enable instruction not honoured at once");

  a_warn_first : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && ovf && (r_q.st == WDT_RUN) && !i_cmd.watchdog_disable_instr
    |=> (r_q.st == WDT_WARN) && r_q.sts[`WDT_EV_WARN] &&
        !o_reset_req)
    else $error("first overflow did not raise prewarning");

  a_reset_after : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && ovf && (r_q.st == WDT_WARN) && !i_cmd.watchdog_disable_instr
    |=> o_reset_req ##1 o_reset_req)
    else $error("second overflow did not request reset");

  a_count_step : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && running && tick && !svc_ok && !ovf
    |=> (r_q.cnt == $past(r_q.cnt) + `WDT_CNT_ONE))
    else $error("counter did not advance by one on tick");

  a_count_hold : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !tick && !svc_ok && !i_bus.wr
    |=> $stable(r_q.cnt))
    else $error("counter moved without a prescaler tick");

  a_ovf_reload : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && ovf |=> (r_q.cnt == $past(r_q.watchdog_reload_value)))
    else $error("overflow did not load reload value");

  a_service_load : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && svc_ok
    |=> (r_q.cnt == $past(r_q.watchdog_reload_value)) &&
        (u_pre.r_q.cnt == '0))
    else $error("service did not reload counter and clear prescaler");

  a_service_cmd : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && svc_ok && (r_q.st == WDT_WARN) &&
    !i_cmd.watchdog_disable_instr
    |=> (r_q.st == WDT_RUN) ##1 !o_reset_req)
    else $error("service in prewarning did not restart counting");

  a_irq_level : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq == |(r_q.sts & r_q.ien))
    else $error("interrupt output disagrees with enabled status");

  a_sticky_set : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && |ev_set |=> |(r_q.sts & $past(ev_set)))
    else $error("event lost against a simultaneous clear");

  a_rdata_once : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !i_bus.rd |=> (o_rdata == '0))
    else $error("read data present without a read strobe");

endmodule

`default_nettype wire

// file: bench/wdt_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module wdt_core_model
  import wdt_pkg::*;
(
  // clock
  input  wire logic     i_clk,
  // instructions to the watchdog
  output var  wdt_cmd_s o_cmd
);
  initial o_cmd = '0;

  // kind 0 enable, 1 disable, 2 service; gap models a slow core
  // the first edge keeps the pulse launched from a rising edge
  task automatic send(input int kind, input int gap);
    @(posedge i_clk);
    repeat (gap) @(posedge i_clk);
    o_cmd.watchdog_enable_instr  <= (kind == 0);
    o_cmd.watchdog_disable_instr <= (kind == 1);
    o_cmd.service                <= (kind == 2);
    @(posedge i_clk);
    o_cmd <= '0;
  endtask
endmodule

`default_nettype wire

// file: bench/watchdog_timer_16bit_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module watchdog_timer_16bit_bench
  import wdt_pkg::*;
;
  logic        i_clk   = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_ce    = 1'b1;
  wdt_bus_s    bus     = '0;
  wdt_cmd_s    cmd;
  logic [15:0] o_rdata;
  logic        o_irq;
  logic        o_reset_req;
  logic [15:0] exp_q[$];
  logic        rd_d    = 1'b0;
  logic [15:0] r;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          cycles     = 0;
  logic [7:0]  ra[8] = '{`WDT_OFF_STATE, `WDT_OFF_CTRL, `WDT_OFF_RELOAD,
                         `WDT_OFF_COUNT, `WDT_OFF_ISTS, `WDT_OFF_IEN,
                         `WDT_OFF_ICLR, 8'h1C};
  logic [15:0] re[8] = '{16'h0001, 16'h0000, `WDT_RELOAD_RST,
                         `WDT_RELOAD_RST, 16'h0000, 16'h0000,
                         16'h0000, 16'h0000};

  always #20 i_clk = ~i_clk;

  wdt_top #(.DIV_SLOW(32)) u_wdt_top (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_cmd       (cmd),
    .i_bus       (bus),
    .o_rdata     (o_rdata),
    .o_irq       (o_irq),
    .o_reset_req (o_reset_req)
  );

  wdt_core_model u_wdt_core_model (
    .i_clk (i_clk),
    .o_cmd (cmd)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '0;
  endtask

  // expected read data goes to the queue, the watcher compares it
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clk);
    exp_q.push_back(e);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
  endtask

  task automatic flags(input logic e_irq, input logic e_rst);
    @(negedge i_clk);
    chk("irq", {15'h0000, e_irq}, {15'h0000, o_irq});
    chk("reset_req", {15'h0000, e_rst}, {15'h0000, o_reset_req});
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (rd_d)
      chk("rdata", exp_q.pop_front(), o_rdata);
    rd_d <= bus.rd;
  end

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      give_verdict;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8000));
    idle(6);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 8; k++) rd(ra[k], re[k]);
    r = 16'($urandom);
    wr(`WDT_OFF_RELOAD, r);
    rd(`WDT_OFF_RELOAD, r);
    // short interval on the slow divider
    wr(`WDT_OFF_RELOAD, 16'hFFFE);
    wr(`WDT_OFF_CTRL, 16'h0001);
    wr(`WDT_OFF_IEN, 16'h0003);
    u_wdt_core_model.send(2, 3);
    rd(`WDT_OFF_COUNT, 16'hFFFE);
    idle(36);
    rd(`WDT_OFF_COUNT, 16'hFFFF);
    idle(30);
    rd(`WDT_OFF_STATE, 16'h0003);
    rd(`WDT_OFF_ISTS, 16'h0001);
    flags(1'b1, 1'b0);
    wr(`WDT_OFF_IEN, 16'h0000);
    idle(2);
    flags(1'b0, 1'b0);
    wr(`WDT_OFF_IEN, 16'h0001);
    idle(2);
    flags(1'b1, 1'b0);
    u_wdt_core_model.send(2, 0);
    rd(`WDT_OFF_STATE, 16'h0001);
    wr(`WDT_OFF_ICLR, 16'h0001);
    idle(2);
    flags(1'b0, 1'b0);
    rd(`WDT_OFF_ISTS, 16'h0000);
    idle(150);
    rd(`WDT_OFF_STATE, 16'h0005);
    rd(`WDT_OFF_ISTS, 16'h0003);
    flags(1'b1, 1'b1);
    // second reset from the reset-request state
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    idle(6);
    i_rst_n <= 1'b1;
    rd(`WDT_OFF_STATE, 16'h0001);
    flags(1'b0, 1'b0);
    u_wdt_core_model.send(1, 0);
    rd(`WDT_OFF_STATE, 16'h0000);
    idle(600);
    rd(`WDT_OFF_COUNT, `WDT_RELOAD_RST);
    u_wdt_core_model.send(0, 5);
    rd(`WDT_OFF_STATE, 16'h0001);
    // default interval: 65536 clocks from a service
    u_wdt_core_model.send(2, 0);
    idle(65300);
    rd(`WDT_OFF_ISTS, 16'h0000);
    idle(400);
    rd(`WDT_OFF_ISTS, 16'h0001);
    idle(3);
    give_verdict;
  end
endmodule

`default_nettype wire
